//--- inc/fet_pkg.sv
package fet_pkg;

  // ****************************************
  // exception bit positions (cause, enable, flag)
  // ****************************************
  localparam int unsigned EXC_INEXACT   = 0;
  localparam int unsigned EXC_UNDERFLOW = 1;
  localparam int unsigned EXC_OVERFLOW  = 2;
  localparam int unsigned EXC_DIVZERO   = 3;
  localparam int unsigned EXC_INVALID   = 4;
  localparam int unsigned EXC_UNIMPL    = 5;
  localparam int unsigned IEEE_W        = 5;
  localparam int unsigned CAUSE_W       = 6;

  // ****************************************
  // rounding modes
  // ****************************************
  localparam logic [1:0] TIES_EVEN_ROUNDING   = 2'h0;
  localparam logic [1:0] TOWARD_ZERO_ROUNDING = 2'h1;
  localparam logic [1:0] TOWARD_PLUS_ROUNDING = 2'h2;
  localparam logic [1:0] TOWARD_MINUS_ROUNDING = 2'h3;

  // ****************************************
  // operation classes reported by the datapath
  // ****************************************
  localparam logic [3:0] OP_ADD     = 4'h0;
  localparam logic [3:0] OP_SUB     = 4'h1;
  localparam logic [3:0] OP_MUL     = 4'h2;
  localparam logic [3:0] OP_DIV     = 4'h3;
  localparam logic [3:0] OP_SQRT    = 4'h4;
  localparam logic [3:0] OP_CVT_FIX = 4'h5;
  localparam logic [3:0] OP_CMP     = 4'h6;
  localparam logic [3:0] OP_FP_REGISTER_MOVE    = 4'h7;
  localparam logic [3:0] OP_FP_CONDITIONAL_MOVE = 4'h8;
  localparam logic [3:0] OP_OTHER   = 4'h9;

  // ****************************************
  // double-precision encodings
  // ****************************************
  localparam logic [63:0] DP_QNAN    = 64'h7FF8_0000_0000_0000;
  localparam logic [62:0] DP_INF_MAG = 63'h7FF0_0000_0000_0000;
  localparam logic [62:0] DP_MAX_MAG = 63'h7FEF_FFFF_FFFF_FFFF;
  localparam int unsigned DP_SIGN    = 63;
  localparam logic [10:0] DP_EXP_ONES = 11'h7FF;
  localparam int unsigned DP_QUIET_BIT = 51;

  // operand classification carried from the datapath
  typedef struct packed {
    logic sign;
    logic is_zero;
    logic is_inf;
    logic is_snan;
    logic is_qnan;
  } fet_opnd_t;

  // one finished operation as reported by the datapath
  typedef struct packed {
    logic [3:0]        op;
    fet_opnd_t         a;
    fet_opnd_t         b;
    logic              res_sign;
    logic              tiny;
    logic              inexact;
    logic              overflow;
    logic              unimpl;
    logic              cvt_ovf;
    logic              cmp_sig;
    logic [63:0]       rounded;
  } fet_op_t;

  // control/status content handled by this block
  typedef struct packed {
    logic [CAUSE_W-1:0] cause;
    logic [IEEE_W-1:0]  enable;
    logic [IEEE_W-1:0]  flag;
    logic [1:0]         rmode;
  } fet_csr_t;

endpackage : fet_pkg

//--- core/fet_exc_unit.sv
`timescale 1ns/100ps
// What this block does
// - precise mode: each arithmetic op with no register write in the same cycle rewrites all cause bits, one per raised condition
// - precise mode: trap when cause and matching enable both set, op or write
// - unimplemented op has no enable, no flag, and always traps
// - precise trap stops the instruction before it writes any result
// - only non-enabled causes: no trap, default result stored, cause readable
// - precise mode: flags change only for completing instructions, not trapping ones
// - ops only set flags; only software writes clear them
// - precise mode always present; imprecise mode chosen by privileged control
// - imprecise mode: unimplemented op still traps precisely, others trap late
// - imprecise mode: cause reads undefined; written cause bits also set flags
// - imprecise mode: every op except an unimplemented one completes, stores default, and records all flags when no register write shares its cycle
// - imprecise mode: trap on enabled condition and on enabled-cause write
// - one condition per op, except inexact with overflow or underflow
// - default result supplied whenever no precise trap is taken
// - invalid gives quiet NaN; divide by zero gives signed infinity
// - underflow, inexact give rounded result; inexact from overflow gives overflow result
// - overflow result follows rounding mode: inf, max finite, or mixed by sign
// - signaling NaN operand is invalid, except register and conditional moves
// - inf minus inf, 0 times inf, 0/0, inf/inf, sqrt negative are invalid
// - float to fixed overflow, infinite or NaN operand is invalid
// - signalling compares flag invalid on quiet NaN
// - divide by zero only for finite nonzero dividend over zero divisor
// - tininess after rounding; accuracy loss judged as inexact
// - inexact also when overflow occurs with overflow trap disabled
module fet_exc_unit
  import fet_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // mode control (privileged)
  input  wire logic        imprecise_mode_i,
  // software move to the control/status register
  input  wire logic        csr_wr_i,
  input  wire fet_csr_t    csr_wdata_i,
  // operation report from the datapath
  input  wire logic        op_valid_i,
  input  wire fet_op_t     op_i,
  // control/status register readback
  output fet_csr_t         fp_control_status_register_o,
  // result and trap towards the pipeline
  output logic             res_valid_o,
  output logic [63:0]      res_data_o,
  output logic             precise_trap_o,
  output logic             imprecise_trap_o
);

  // ****************************************
  // condition detection
  // ****************************************
  fet_csr_t          csr_r, csr_nxt;
  logic [CAUSE_W-1:0] cond;
  logic              nan_in, snan_in, inv, dz, ovf_en, unf, inx;

  // ieee conditions of the current op
  always_comb begin
    nan_in  = op_i.a.is_snan | op_i.b.is_snan;
    // moves are exempt from signaling-NaN invalid
    snan_in = nan_in & (op_i.op != OP_FP_REGISTER_MOVE)
                     & (op_i.op != OP_FP_CONDITIONAL_MOVE);
    inv = snan_in;
    dz  = 1'b0;
    unique case (op_i.op)
      OP_ADD:     inv = inv | (op_i.a.is_inf & op_i.b.is_inf
                               & (op_i.a.sign != op_i.b.sign));
      OP_SUB:     inv = inv | (op_i.a.is_inf & op_i.b.is_inf
                               & (op_i.a.sign == op_i.b.sign));
      OP_MUL:     inv = inv | (op_i.a.is_zero & op_i.b.is_inf)
                            | (op_i.a.is_inf & op_i.b.is_zero);
      OP_DIV: begin
        inv = inv | (op_i.a.is_zero & op_i.b.is_zero)
                  | (op_i.a.is_inf & op_i.b.is_inf);
        // finite nonzero over zero only; inf/0 is exact infinity
        dz  = op_i.b.is_zero & ~op_i.a.is_zero & ~op_i.a.is_inf
              & ~op_i.a.is_snan & ~op_i.a.is_qnan;
      end
      // -0 is a valid root operand
      OP_SQRT:    inv = inv | (op_i.a.sign & ~op_i.a.is_zero
                               & ~op_i.a.is_qnan);
      OP_CVT_FIX: inv = inv | op_i.cvt_ovf | op_i.a.is_inf
                            | op_i.a.is_qnan;
      OP_CMP:     inv = inv | (op_i.cmp_sig
                               & (op_i.a.is_qnan | op_i.b.is_qnan));
      default:    inv = inv;
    endcase
    ovf_en = csr_r.enable[EXC_OVERFLOW];
    // tiny is after rounding; untrapped needs loss of accuracy
    unf = op_i.tiny & (csr_r.enable[EXC_UNDERFLOW] | op_i.inexact);
    inx = op_i.inexact | (op_i.overflow & ~ovf_en);
    cond = '0;
    // a single condition wins; only inexact may ride along
    if (op_i.unimpl) begin
      cond[EXC_UNIMPL] = 1'b1;
    end else if (inv) begin
      cond[EXC_INVALID] = 1'b1;
    end else if (dz) begin
      cond[EXC_DIVZERO] = 1'b1;
    end else begin
      cond[EXC_OVERFLOW]  = op_i.overflow;
      cond[EXC_UNDERFLOW] = unf & ~op_i.overflow;
      cond[EXC_INEXACT]   = inx;
    end
  end

  // ****************************************
  // default result selection
  // ****************************************
  logic [63:0] dflt;
  logic        s;

  always_comb begin
    s    = op_i.res_sign;
    dflt = op_i.rounded;
    if (cond[EXC_INVALID]) begin
      dflt = DP_QNAN;
    end else if (cond[EXC_DIVZERO]) begin
      dflt = {s, DP_INF_MAG};
    end else if (cond[EXC_OVERFLOW]) begin
      // the overflowed value also serves an accompanying inexact
      unique case (csr_r.rmode)
        TIES_EVEN_ROUNDING:   dflt = {s, DP_INF_MAG};
        TOWARD_ZERO_ROUNDING: dflt = {s, DP_MAX_MAG};
        TOWARD_PLUS_ROUNDING: dflt = s ? {s, DP_MAX_MAG} : {s, DP_INF_MAG};
        TOWARD_MINUS_ROUNDING: dflt = s ? {s, DP_INF_MAG} : {s, DP_MAX_MAG};
      endcase
    end
  end

  // ****************************************
  // trap decision and register update
  // ****************************************
  logic [IEEE_W-1:0] hit;
  logic              ptrap, itrap, wr_trap, complete;
  logic              res_valid_nxt, ptrap_nxt, itrap_nxt;
  logic [63:0]       res_nxt;

  always_comb begin
    hit      = cond[IEEE_W-1:0] & csr_r.enable;
    // unimplemented always traps precisely, in either mode
    ptrap    = op_valid_i & (cond[EXC_UNIMPL]
               | (~imprecise_mode_i & (|hit)));
    itrap    = op_valid_i & imprecise_mode_i & ~cond[EXC_UNIMPL]
               & (|hit);
    // a write with an enabled cause traps in both modes
    wr_trap  = csr_wr_i & ((|(csr_wdata_i.cause[IEEE_W-1:0] & csr_wdata_i.enable))
               | csr_wdata_i.cause[EXC_UNIMPL]);
    complete = op_valid_i & ~ptrap;
    csr_nxt  = csr_r;
    if (csr_wr_i) begin
      // software is the only agent that may clear flags
      csr_nxt = csr_wdata_i;
      if (imprecise_mode_i) begin
        csr_nxt.flag = csr_wdata_i.flag | csr_wdata_i.cause[IEEE_W-1:0];
      end
    end else if (op_valid_i) begin
      // cause shows this op's conditions, also when untrapped
      csr_nxt.cause = cond;
      if (complete) begin
        csr_nxt.flag = csr_r.flag | cond[IEEE_W-1:0];
      end
    end
    // results only leave for completing ops, defaults included
    res_valid_nxt = complete;
    res_nxt       = complete ? dflt : res_data_o;
    ptrap_nxt     = ptrap | (wr_trap & ~imprecise_mode_i);
    itrap_nxt     = itrap | (wr_trap & imprecise_mode_i);
  end

  // state registers; csr content is software-initialised, reset value is zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      csr_r            <= '0;
      res_valid_o      <= 1'b0;
      res_data_o       <= '0;
      precise_trap_o   <= 1'b0;
      imprecise_trap_o <= 1'b0;
    end else begin
      csr_r            <= csr_nxt;
      res_valid_o      <= res_valid_nxt;
      res_data_o       <= res_nxt;
      precise_trap_o   <= ptrap_nxt;
      imprecise_trap_o <= itrap_nxt;
    end
  end

  // readback of the register
  assign fp_control_status_register_o = csr_r;

endmodule : fet_exc_unit

//--- dv/fet_exc_unit_asserts.sv
`timescale 1ns/100ps
// ****************************************
// port checker for the exception unit
// ****************************************
module fet_exc_unit_chk
  import fet_pkg::*;
(
  // clock, reset and stimulus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        imprecise_mode_i,
  input wire logic        csr_wr_i,
  input wire fet_csr_t    csr_wdata_i,
  input wire logic        op_valid_i,
  input wire fet_op_t     op_i,
  // design outputs
  input wire fet_csr_t    fp_control_status_register_o,
  input wire logic        res_valid_o,
  input wire logic [63:0] res_data_o,
  input wire logic        precise_trap_o,
  input wire logic        imprecise_trap_o
);
  default clocking dcb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // short views of the readback flags and the written cause
  wire logic [4:0] fl = fp_control_status_register_o.flag;
  wire logic [4:0] wc = csr_wdata_i.cause[4:0];
  wire logic       hit = csr_wr_i && ((wc & csr_wdata_i.enable) != 5'h00);

  a_trap_no_result: assert property (precise_trap_o |-> !res_valid_o)
    else $error("precise trap came with a result");
  a_flag_only_set: assert property (!csr_wr_i |=> (($past(fl) & ~fl) == 5'h00))
    else $error("flag cleared without a write");
  a_unimpl_traps: assert property (op_valid_i && op_i.unimpl |=> precise_trap_o)
    else $error("unimplemented op did not trap precisely");
  a_wr_trap_prec: assert property (hit && !imprecise_mode_i |=> precise_trap_o)
    else $error("enabled cause write gave no precise trap");
  a_wr_trap_imp: assert property (hit && imprecise_mode_i |=> imprecise_trap_o)
    else $error("enabled cause write gave no imprecise trap");
  a_imp_complete: assert property (op_valid_i && imprecise_mode_i && !op_i.unimpl
    |=> res_valid_o)
    else $error("imprecise op did not complete");
  a_trap_flag_kept: assert property (precise_trap_o && !$past(csr_wr_i) |-> $stable(fl))
    else $error("trapping op changed flags");
  a_imp_wr_flag: assert property (csr_wr_i && imprecise_mode_i
    |=> ((fl & $past(wc)) == $past(wc)))
    else $error("written cause bit did not set flag");
  // main scenarios reached
  c_prec_trap: cover property (precise_trap_o);
  c_imp_trap: cover property (imprecise_trap_o);
  c_ovf_done: cover property (res_valid_o && fp_control_status_register_o.cause[EXC_OVERFLOW]);
endmodule : fet_exc_unit_chk

bind fet_exc_unit fet_exc_unit_chk u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .imprecise_mode_i(imprecise_mode_i),
  .csr_wr_i(csr_wr_i), .csr_wdata_i(csr_wdata_i), .op_valid_i(op_valid_i), .op_i(op_i),
  .fp_control_status_register_o(fp_control_status_register_o), .res_valid_o(res_valid_o),
  .res_data_o(res_data_o), .precise_trap_o(precise_trap_o),
  .imprecise_trap_o(imprecise_trap_o));

//--- dv/fet_pipe_model.sv
`timescale 1ns/100ps
// ****************************************
// pipeline side: takes trap pulses
// ****************************************
module fet_pipe_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // traps from the exception unit
  input  wire logic       precise_trap_i,
  input  wire logic       imprecise_trap_i,
  // traps taken so far
  output logic      [7:0] trap_cnt_o
);
  // one count per pulse; a trap that stood two cycles would be taken twice
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      trap_cnt_o <= 8'h00;
    end else if (precise_trap_i || imprecise_trap_i) begin
      trap_cnt_o <= trap_cnt_o + 8'h01;
    end
  end
endmodule : fet_pipe_model

//--- dv/tb_top.sv
`timescale 1ns/100ps
// ****************************************
// directed bench for the exception unit
// ****************************************
module tb_top;
  import fet_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        imp = 1'b0;
  logic        wr = 1'b0;
  logic        vld = 1'b0;
  fet_csr_t    c = '0;
  fet_op_t     o = '0;
  fet_csr_t    csr;
  logic        rv, pt, it;
  logic [63:0] rd;
  logic [7:0]  ntrap;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  fet_exc_unit u_dut (.clk_i(clk_i), .rst_i(rst_i), .imprecise_mode_i(imp), .csr_wr_i(wr),
    .csr_wdata_i(c), .op_valid_i(vld), .op_i(o), .fp_control_status_register_o(csr),
    .res_valid_o(rv), .res_data_o(rd), .precise_trap_o(pt), .imprecise_trap_o(it));
  fet_pipe_model u_pipe (.clk_i(clk_i), .rst_i(rst_i), .precise_trap_i(pt),
    .imprecise_trap_i(it), .trap_cnt_o(ntrap));

  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // hang guard, far above the roughly 95 cycles used
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 2000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  // wide enough for the packed groups compared below, so no bit is dropped
  task chk(input string n, input logic [127:0] s, input logic [127:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // one request; outputs stand at the returning falling edge
  task run(input logic w, input logic v);
    @(negedge clk_i);
    wr = w;
    vld = v;
    @(negedge clk_i);
    wr = 1'b0;
    vld = 1'b0;
  endtask : run

  task t_div;
    run(1'b1, 1'b0);
    o.op = OP_DIV;
    o.b.is_zero = 1'b1;
    o.res_sign = 1'b1;
    run(1'b0, 1'b1);
    chk("div_res", {rv, rd}, {1'b1, 1'b1, DP_INF_MAG});
    chk("div_cause", csr.cause, 6'h08);
    o = '0;
    o.rounded = 64'h3FF0_0000_0000_0000;
    run(1'b0, 1'b1);
    chk("add_res", rd, 64'h3FF0_0000_0000_0000);
    chk("add_csr", {csr.cause, csr.flag}, {6'h00, 5'h08});
    c.flag = 5'h08;
    c.enable = 5'h08;
    run(1'b1, 1'b0);
    o.op = OP_DIV;
    o.b.is_zero = 1'b1;
    run(1'b0, 1'b1);
    chk("div_trap", {pt, rv, csr.flag}, {2'h2, 5'h08});
    run(1'b1, 1'b0); // handler clears the enabled cause
    c.cause = 6'h08;
    run(1'b1, 1'b0);
    chk("wr_trap", pt, 1'b1);
    c = '0;
    run(1'b1, 1'b0);
    $display("t_div done");
  endtask : t_div

  task t_ovf;
    logic [63:0] e;
    for (int m = 0; m < 8; m++) begin
      c.rmode = m[1:0];
      run(1'b1, 1'b0);
      o = '0;
      o.op = OP_MUL;
      o.overflow = 1'b1;
      o.inexact = 1'b1;
      o.res_sign = m[2];
      run(1'b0, 1'b1);
      e = (m[1:0] == 0 || ((m[1:0] == 2) ^ m[2]) && m[1]) ? {m[2], DP_INF_MAG}
                                                         : {m[2], DP_MAX_MAG};
      chk("ovf_res", rd, e);
      chk("ovf_cause", csr.cause, 6'h05);
    end
    $display("t_ovf done");
  endtask : t_ovf

  task t_inv;
    for (int k = 0; k < 12; k++) begin
      o = '0;
      o.rounded = 64'h0000_0000_0000_1234;
      // operand classes set field by field; a flat concatenation would misplace them
      case (k)
        0: o.a.is_snan = 1'b1;
        1: begin
          o.op = OP_SUB;
          o.a.is_inf = 1'b1;
          o.b.is_inf = 1'b1;
        end
        2: begin
          o.op = OP_ADD;
          o.a.is_inf = 1'b1;
          o.b.is_inf = 1'b1;
          o.b.sign = 1'b1;
        end
        3: begin
          o.op = OP_MUL;
          o.a.is_zero = 1'b1;
          o.b.is_inf = 1'b1;
        end
        4: begin
          o.op = OP_DIV;
          o.a.is_zero = 1'b1;
          o.b.is_zero = 1'b1;
        end
        5: begin
          o.op = OP_DIV;
          o.a.is_inf = 1'b1;
          o.b.is_inf = 1'b1;
        end
        6: begin
          o.op = OP_SQRT;
          o.a.sign = 1'b1;
        end
        7: begin
          o.op = OP_CVT_FIX;
          o.cvt_ovf = 1'b1;
        end
        8: begin
          o.op = OP_CMP;
          o.cmp_sig = 1'b1;
          o.a.is_qnan = 1'b1;
        end
        9: begin
          o.op = OP_FP_REGISTER_MOVE;
          o.a.is_snan = 1'b1;
        end
        10: begin
          o.op = OP_FP_CONDITIONAL_MOVE;
          o.a.is_snan = 1'b1;
        end
        default: begin
          o.op = OP_SQRT;
          o.a.sign = 1'b1;
          o.a.is_zero = 1'b1;
        end
      endcase
      run(1'b0, 1'b1);
      chk("inv_res", rd, (k < 9) ? DP_QNAN : 64'h1234);
      chk("inv_cause", csr.cause, (k < 9) ? 6'h10 : 6'h00);
    end
    o = '0;
    o.tiny = 1'b1;
    o.inexact = 1'b1;
    run(1'b0, 1'b1);
    chk("unf", {csr.cause, rd}, {6'h03, 64'h0});
    $display("t_inv done");
  endtask : t_inv

  task t_unimpl;
    for (int m = 0; m < 2; m++) begin
      imp = m[0];
      c = '0;
      run(1'b1, 1'b0);
      o = '0;
      o.op = OP_OTHER;
      o.unimpl = 1'b1;
      run(1'b0, 1'b1);
      chk("unimpl", {pt, it, rv, csr.flag}, {3'h4, 5'h00});
      if (m == 0) chk("unimpl_cause", csr.cause, 6'h20);
    end
    $display("t_unimpl done");
  endtask : t_unimpl

  task t_imp;
    c = '0;
    c.enable = 5'h01;
    run(1'b1, 1'b0);
    o = '0;
    o.inexact = 1'b1;
    o.rounded = 64'h0000_0000_0000_0055;
    run(1'b0, 1'b1);
    chk("imp_op", {pt, it, rv, rd}, {3'h3, 64'h55});
    chk("imp_flag", csr.flag, 5'h01);
    c = '0;
    c.cause = 6'h02;
    run(1'b1, 1'b0);
    chk("imp_wr_flag", csr.flag & 5'h02, 5'h02);
    c.enable = 5'h02;
    run(1'b1, 1'b0);
    chk("imp_wr_trap", {pt, it}, 2'h1);
    c = '0;
    run(1'b1, 1'b0);
    imp = 1'b0;
    $display("t_imp done");
  endtask : t_imp

  initial begin
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    t_div();
    t_ovf();
    t_inv();
    t_unimpl();
    t_imp();
    chk("traps", ntrap, 8'h06);
    tally_and_finish();
  end
endmodule : tb_top
